// ==== rtl/system_clock_select_and_cycle_gen.sv ====
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Core timing source select, machine cycle generator, reset pin driver.
module system_clock_select_and_cycle_gen (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic main_osc_in,
  input wire logic sub_osc_in,
  input wire clk_ctl_pkg::reg_req_t reg_req,
  output logic [3:0] reg_rdata,
  input wire logic wdt_reset,
  input wire logic lvd_reset,
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  output logic core_timing_source,
  output logic cpu_cycle_tick,
  output logic sys_reset_req
);

  // ************************************************************
  // Declarations
  // ************************************************************
  // Software copy of the select register
  logic [3:0] clock_select_control_r;
  // Selection actually in force
  clk_ctl_pkg::src_sel_t active_sel_r;
  // Prescalers for the divided sources
  logic [1:0] main_pre_r;
  logic [1:0] sub_pre_r;
  // Machine cycle phase counter
  logic [1:0] phase_r;
  // Registered outputs
  logic [3:0] rdata_r;
  logic src_tick_r;
  logic cyc_tick_r;
  logic pin_oe_r;
  logic rst_req_r;
  // Raw oscillator edges
  logic main_tick;
  logic sub_tick;
  // Combinational source tick
  logic src_tick;
  logic [1:0] sel_req;
  logic cyc_end;

  // Oscillator edge detectors
  osc_edge_det u_main_edge (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .osc_in(main_osc_in),
    .tick(main_tick)
  );
  osc_edge_det u_sub_edge (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .osc_in(sub_osc_in),
    .tick(sub_tick)
  );

  // ************************************************************
  // Register bus
  // ************************************************************
  // Control register write
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      clock_select_control_r <= clk_ctl_pkg::CLK_SEL_RST;
    end
    else if (reg_req.wr && reg_req.addr == clk_ctl_pkg::CLK_SEL_OFS)
    begin
      clock_select_control_r <= reg_req.wdata;
    end
  end

  // Read data, one cycle after the strobe; zero otherwise
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rdata_r <= 4'h0;
    end
    else if (reg_req.rd)
    begin
      unique case (reg_req.addr)
        clk_ctl_pkg::CLK_SEL_OFS: rdata_r <= clock_select_control_r;
        // Live selection and cycle phase
        clk_ctl_pkg::CLK_STAT_OFS: rdata_r <= {active_sel_r, phase_r};
        // Unmapped reads as zero
        default: rdata_r <= 4'h0;
      endcase
    end
    else
    begin
      rdata_r <= 4'h0;
    end
  end

  // ************************************************************
  // Source selection
  // ************************************************************
  // Select bits decode
  assign sel_req = {clock_select_control_r[clk_ctl_pkg::SEL_HI_POS],
                    clock_select_control_r[clk_ctl_pkg::SEL_LO_POS]};

  // Prescalers count freely, whatever the selection, so a switch can meet a partial count
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      main_pre_r <= 2'h0;
      sub_pre_r <= 2'h0;
    end
    else
    begin
      if (main_tick)
      begin
        main_pre_r <= main_pre_r + 2'h1;
      end
      if (sub_tick)
      begin
        sub_pre_r <= sub_pre_r + 2'h1;
      end
    end
  end

  always_comb
  begin
    unique case (active_sel_r)
      clk_ctl_pkg::SRC_MAIN: src_tick = main_tick;
      clk_ctl_pkg::SRC_SUB: src_tick = sub_tick;
      clk_ctl_pkg::SRC_MAIN_DIV4:
        src_tick = main_tick && main_pre_r == clk_ctl_pkg::PRE_DIV_LAST;
      clk_ctl_pkg::SRC_SUB_DIV4:
        src_tick = sub_tick && sub_pre_r == clk_ctl_pkg::PRE_DIV_LAST;
      default: src_tick = 1'b0;
    endcase
  end

  // ************************************************************
  // Machine cycle generation
  // ************************************************************
  // Last source tick of a machine cycle
  assign cyc_end = src_tick && phase_r == clk_ctl_pkg::CYC_DIV_LAST;

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      phase_r <= 2'h0;
    end
    else if (cyc_end)
    begin
      phase_r <= 2'h0;
    end
    else if (src_tick)
    begin
      phase_r <= phase_r + 2'h1;
    end
  end

  // Switch at cycle boundary
  // Applying only at cycle end avoids a short machine cycle
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      active_sel_r <= clk_ctl_pkg::SRC_MAIN_DIV4;
    end
    else if (cyc_end)
    begin
      active_sel_r <= clk_ctl_pkg::src_sel_t'(sel_req);
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      src_tick_r <= 1'b0;
      cyc_tick_r <= 1'b0;
    end
    else
    begin
      src_tick_r <= src_tick;
      cyc_tick_r <= cyc_end;
    end
  end

  // ************************************************************
  // Reset pin
  // ************************************************************
  // Open-drain low drive
  // Pin input is also sampled so an external low resets the system
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_oe_r <= 1'b0;
      rst_req_r <= 1'b0;
    end
    else
    begin
      pin_oe_r <= wdt_reset | lvd_reset;
      rst_req_r <= wdt_reset | lvd_reset | ~reset_pin_in;
    end
  end

  assign reg_rdata = rdata_r;
  assign core_timing_source = src_tick_r;
  assign cpu_cycle_tick = cyc_tick_r;
  assign reset_pin_oe = pin_oe_r;
  assign reset_pin_out = 1'b0;
  assign sys_reset_req = rst_req_r;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  sel_reset_a: assert property ($rose(rst_b) |-> active_sel_r == clk_ctl_pkg::SRC_MAIN_DIV4)
    else $error("Selection after reset not main div4");
  sel_boundary_a: assert property (!$past(cyc_end) |-> $stable(active_sel_r))
    else $error("Selection changed mid cycle");
  cyc_three_a: assert property (src_tick && phase_r == 2'h2 |=> cpu_cycle_tick && phase_r == 2'h0)
    else $error("Cycle did not end on the third tick");
  phase_range_a: assert property (phase_r != 2'h3)
    else $error("Cycle phase out of range");
  cyc_tick_a: assert property (cyc_end |=> cpu_cycle_tick)
    else $error("Cycle tick missing");
  sub_map_a: assert property (active_sel_r == clk_ctl_pkg::SRC_SUB |-> src_tick == sub_tick)
    else $error("Sub selection wrong");
  div4_map_a: assert property (active_sel_r == clk_ctl_pkg::SRC_MAIN_DIV4 && src_tick
    |-> main_tick && main_pre_r == 2'h3)
    else $error("Main div4 tick wrong");
  pin_drive_a: assert property ((wdt_reset || lvd_reset) |=> reset_pin_oe && !reset_pin_out)
    else $error("Reset pin not driven low");
  pin_release_a: assert property (!(wdt_reset || lvd_reset) |=> !reset_pin_oe)
    else $error("Reset pin driven without cause");

  switch_c: cover property (cyc_end && sel_req != active_sel_r);
  wdt_c: cover property (wdt_reset ##1 reset_pin_oe);
  cycle_c: cover property (cpu_cycle_tick ##[1:40] cpu_cycle_tick);

endmodule
`default_nettype wire

// ==== common/clk_ctl_pkg.sv ====
`default_nettype none
package clk_ctl_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  // Clock select control register index
  localparam logic [1:0] CLK_SEL_OFS = 2'h0;
  // Status register index: live source and cycle phase
  localparam logic [1:0] CLK_STAT_OFS = 2'h1;
  // Field positions in the control register
  localparam int SEL_LO_POS = 0;
  localparam int SEL_HI_POS = 3;
  // Reset value: main input divided by four (bit 3 set)
  localparam logic [3:0] CLK_SEL_RST = 4'h8;

  // ************************************************************
  // Timing counts
  // ************************************************************
  // Prescale for the divided sources
  localparam logic [1:0] PRE_DIV_LAST = 2'h3;
  // Machine cycle is three source ticks
  localparam logic [1:0] CYC_DIV_LAST = 2'h2;

  // Source selection codes, {bit3, bit0}
  typedef enum logic [1:0] {
    SRC_MAIN = 2'h0,
    SRC_SUB = 2'h1,
    SRC_MAIN_DIV4 = 2'h2,
    SRC_SUB_DIV4 = 2'h3
  } src_sel_t;

  // Register bus request bundle
  typedef struct packed {
    logic [1:0] addr;
    logic [3:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage
`default_nettype wire

// ==== rtl/osc_edge_det.sv ====
`timescale 1ns/1ps
`default_nettype none
// Converts one synchronous oscillator level into a rising-edge tick.
module osc_edge_det (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic osc_in,
  output logic tick
);

  // Previous sample of the oscillator level
  logic prev_r;

  // ************************************************************
  // Edge detection
  // ************************************************************
  // Inputs are synchronous, so no synchroniser stage is needed
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prev_r <= 1'b0;
    end
    else
    begin
      prev_r <= osc_in;
    end
  end

  // One core_clk pulse per oscillator rising edge
  assign tick = osc_in & ~prev_r;

endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ************************************************************
  // Stimulus and observed signals
  // ************************************************************
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic main_osc_in = 1'b0;
  logic sub_osc_in = 1'b0;
  clk_ctl_pkg::reg_req_t reg_req = '0;
  logic wdt_reset = 1'b0;
  logic lvd_reset = 1'b0;
  // Outside driver of the reset pin, high by the pull-up
  logic ext_pin_b = 1'b1;
  logic [3:0] reg_rdata;
  logic reset_pin_out;
  logic reset_pin_oe;
  logic core_timing_source;
  logic cpu_cycle_tick;
  logic sys_reset_req;
  // Wire level: the block wins while it drives low
  wire logic pin_lvl = reset_pin_oe ? reset_pin_out : ext_pin_b;
  int num_errors = 0;
  int samples_checked = 0;
  // Pulse tallies: src_n and cyc_n free-running, measured by difference; run_n restarts each cycle
  int src_n = 0;
  int cyc_n = 0;
  int run_n = 0;
  logic [3:0] rd_val;

  system_clock_select_and_cycle_gen system_clock_select_and_cycle_gen_i (
    .core_clk(core_clk), .rst_b(rst_b), .main_osc_in(main_osc_in),
    .sub_osc_in(sub_osc_in), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .wdt_reset(wdt_reset), .lvd_reset(lvd_reset), .reset_pin_in(pin_lvl),
    .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
    .core_timing_source(core_timing_source), .cpu_cycle_tick(cpu_cycle_tick),
    .sys_reset_req(sys_reset_req)
  );

  // 100 ns period
  always #50 core_clk = ~core_clk;

  task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      $display("wrong value %s expected %h seen %h", what, exp, seen);
      num_errors++;
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Pulse tally; every machine cycle must hold three source ticks
  // Sampled mid-cycle so the registered outputs have settled
  always @(negedge core_clk)
  begin
    if (rst_b)
    begin
      if (cpu_cycle_tick)
      begin
        check("ticks per cycle", 4'(run_n + 32'(core_timing_source)), 4'h3);
        run_n = 0;
        cyc_n++;
      end
      else if (core_timing_source)
        run_n++;
      if (core_timing_source)
        src_n++;
    end
  end

  // Bus tasks: one-cycle strobes, data read in the following cycle
  task automatic wr(input logic [1:0] a, input logic [3:0] d);
    @(posedge core_clk);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    reg_req <= '0;
  endtask

  task automatic rd(input logic [1:0] a);
    @(posedge core_clk);
    reg_req <= '{addr: a, wdata: 4'h0, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    reg_req <= '0;
    #1 rd_val = reg_rdata;
  endtask

  // One oscillator period of five core cycles, well under 5 MHz
  task automatic pulse(input logic m, input logic s);
    @(posedge core_clk);
    main_osc_in <= m;
    sub_osc_in <= s;
    repeat (2) @(posedge core_clk);
    main_osc_in <= 1'b0;
    sub_osc_in <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask

  // Edges on each oscillator in turn; only the selected one may count
  task automatic measure(input string what, input int n, input int e_src, input int e_cyc);
    int s0;
    int c0;
    s0 = src_n;
    c0 = cyc_n;
    repeat (n) pulse(1'b1, 1'b0);
    repeat (n) pulse(1'b0, 1'b1);
    repeat (3) @(posedge core_clk);
    check({what, " ticks"}, 4'(src_n - s0), 4'(e_src));
    check({what, " cycles"}, 4'(cyc_n - c0), 4'(e_cyc));
  endtask

  // Switch waits for a cycle end, so both oscillators are pulsed
  task automatic set_sel(input logic [3:0] v);
    int i;
    wr(clk_ctl_pkg::CLK_SEL_OFS, v);
    rd(clk_ctl_pkg::CLK_SEL_OFS);
    check("control", rd_val, v);
    for (i = 0; i < 40; i++)
    begin
      rd(clk_ctl_pkg::CLK_STAT_OFS);
      if (rd_val[3:2] === {v[3], v[0]})
        break;
      pulse(1'b1, 1'b1);
    end
    if (i == 40)
    begin
      num_errors++;
      wrap_up();
    end
    check("phase at switch", {2'h0, rd_val[1:0]}, 4'h0);
  endtask

  task automatic t_reset;
    rd(clk_ctl_pkg::CLK_SEL_OFS);
    check("control at reset", rd_val, clk_ctl_pkg::CLK_SEL_RST);
    rd(clk_ctl_pkg::CLK_STAT_OFS);
    check("status at reset", rd_val, 4'h8);
    measure("default", 12, 3, 1);
    $display("test reset done");
  endtask

  // Status is read-only, upper offsets read as zero
  task automatic t_regs;
    wr(clk_ctl_pkg::CLK_STAT_OFS, 4'h5);
    wr(2'h2, 4'h7);
    rd(clk_ctl_pkg::CLK_SEL_OFS);
    check("control kept", rd_val, 4'h8);
    // Read data stands for one cycle only
    @(posedge core_clk);
    #1 check("read data cleared", reg_rdata, 4'h0);
    rd(2'h2);
    check("offset 2", rd_val, 4'h0);
    rd(2'h3);
    check("offset 3", rd_val, 4'h0);
    $display("test registers done");
  endtask

  // All four codes, with the unused bits set too
  task automatic t_sel;
    logic [3:0] vals [4] = '{4'h6, 4'h7, 4'he, 4'hf};
    int ns [4] = '{6, 6, 12, 12};
    int es [4] = '{6, 6, 3, 3};
    int ec [4] = '{2, 2, 1, 1};
    for (int k = 0; k < 4; k++)
    begin
      set_sel(vals[k]);
      measure("selected", ns[k], es[k], ec[k]);
    end
    $display("test selection done");
  endtask

  // Watchdog then brownout, then an outside low on the pin
  task automatic t_pin;
    for (int k = 0; k < 2; k++)
    begin
      @(posedge core_clk);
      wdt_reset <= (k == 0);
      lvd_reset <= (k == 1);
      @(posedge core_clk);
      wdt_reset <= 1'b0;
      lvd_reset <= 1'b0;
      #1 check("pin drive", 4'(reset_pin_oe), 4'h1);
      check("pin low", 4'(reset_pin_out), 4'h0);
      check("reset request", 4'(sys_reset_req), 4'h1);
      repeat (2) @(posedge core_clk);
      #1 check("pin released", 4'(reset_pin_oe), 4'h0);
      check("request released", 4'(sys_reset_req), 4'h0);
    end
    @(posedge core_clk);
    ext_pin_b <= 1'b0;
    @(posedge core_clk);
    ext_pin_b <= 1'b1;
    #1 check("outside reset", 4'(sys_reset_req), 4'h1);
    check("no drive on input", 4'(reset_pin_oe), 4'h0);
    @(posedge core_clk);
    #1 check("outside released", 4'(sys_reset_req), 4'h0);
    $display("test reset pin done");
  endtask

  initial
  begin
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    t_reset();
    t_regs();
    t_sel();
    t_pin();
    wrap_up();
  end

  // Hang guard, about 20000 cycles
  initial
  begin
    #2000000;
    num_errors++;
    wrap_up();
  end
endmodule
`default_nettype wire
